/* src/optical_mgmt_pkg.sv */
// constants, map layout and state type for the module management block
// assumes a 200 MHz ref_clk and a host-driven two-wire serial clock
package optical_mgmt_pkg;

  // timing
  localparam int unsigned REF_CLK_KHZ      = 200000;  // ref_clk rate
  localparam int unsigned LASER_SWITCH_MS  = 100;     // longest switch time
  localparam int unsigned LASER_SWITCH_CYC = LASER_SWITCH_MS * REF_CLK_KHZ;
  localparam int unsigned INIT_CYC         = 64;      // init before ready
  localparam int unsigned PD_HOLD_CYC      = 16;      // reset pulse length

  // two-wire device address
  localparam logic [6:0] DEV_ADDR = 7'h50;

  // memory map
  localparam int unsigned N_MON     = 5;      // live monitor bytes
  localparam int unsigned N_THR     = 20;     // threshold bytes
  localparam logic [7:0]  ADDR_MON0 = 8'h00;  // temp,bias,txpow,rxpow,vcc
  localparam logic [7:0]  ADDR_ALRM = 8'h05;  // alarm flags
  localparam logic [7:0]  ADDR_WARN = 8'h06;  // warning flags
  localparam logic [7:0]  ADDR_STAT = 8'h07;  // pin status
  localparam logic [7:0]  ADDR_THR0 = 8'h08;  // first writable byte
  localparam logic [7:0]  ADDR_MAX  = 8'h1B;  // highest location

  // threshold groups inside the writable area
  localparam int unsigned THR_AHI = 0;   // alarm high
  localparam int unsigned THR_ALO = 5;   // alarm low
  localparam int unsigned THR_WHI = 10;  // warning high
  localparam int unsigned THR_WLO = 15;  // warning low
  localparam logic [7:0]  AHI_RST = 8'hF0;
  localparam logic [7:0]  ALO_RST = 8'h10;
  localparam logic [7:0]  WHI_RST = 8'hE0;
  localparam logic [7:0]  WLO_RST = 8'h20;

  // status byte bits
  localparam int unsigned STAT_LOS   = 0;
  localparam int unsigned STAT_LOFF  = 1;
  localparam int unsigned STAT_NR    = 2;
  localparam int unsigned STAT_PDOWN = 3;

  // link engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
    ST_WDATA, ST_ACK_W, ST_RDATA, ST_ACK_R
  } link_state_t;

endpackage : optical_mgmt_pkg

/* src/pin_sync.sv */
// two flip-flop synchroniser for a group of independent levels
// assumes each bit is a slow level from another domain or a pin
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int unsigned   W       = 1,
  parameter logic [W-1:0]  RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;  // first stage, read only by q

  // two stages, reset to a constant
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : pin_sync

`default_nettype wire

/* src/optical_module_mgmt_control.sv */
// management and control logic of a pluggable optical module
// assumes host pull-ups on every open-collector line and on sda,
// a host-driven serial clock and a running ref_clk
//
// Functional notes
// - only answer while module select held low
// - pull interrupt low while a flag pends
// - disable input high turns laser off
// - laser switches within 100 ms
// - absent line always pulled low
// - loss-of-signal output reports optical input
// - lost signal high, normal reception low
// - status outputs only pull low or release
// - power-down high keeps module in standby
// - power-down falling edge starts module reset
// - that reset clears everything, serial link too
// - write on rising edge, protected bytes kept
// - read data bit changes on falling edge
// - data line driven only in own turn
// - each address selects one byte
// - random and auto-advancing sequential access
// - live monitor values readable in map
// - flags set when value leaves range
// - works with no reference clock supplied; here the module stays in reset without ref_clk
`timescale 1ns/1ps
`default_nettype none

module optical_module_mgmt_control
  import optical_mgmt_pkg::*;
#(
  parameter int unsigned SWITCH_CYC = LASER_SWITCH_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  input  wire logic       module_select_n,
  input  wire logic       laser_off_request,
  input  wire logic       power_down,
  input  wire logic       optical_los_in,
  input  wire logic [7:0] temp_val,
  input  wire logic [7:0] bias_val,
  input  wire logic [7:0] txpow_val,
  input  wire logic [7:0] rxpow_val,
  input  wire logic [7:0] vcc_val,
  output logic            laser_enable,
  output logic            standby,
  output logic            irq_n_o,
  output logic            irq_n_oe_n,
  output logic            absent_o,
  output logic            absent_oe_n,
  output logic            not_ready_flag_o,
  output logic            not_ready_flag_oe_n,
  output logic            rx_signal_lost_o,
  output logic            rx_signal_lost_oe_n
);

  // reset and pins, ref_clk domain
  logic [1:0]  rst_sync_q;       // arst_n release chain
  logic        rst_n_s;          // released system reset
  logic [3:0]  pins_s;           // synchronised pins and busy
  logic        dis_s;            // laser disable request
  logic        pd_s;             // power-down level
  logic        los_s;            // optical loss detector
  logic        busy_s;           // link transaction open
  logic        pd_prev_q;        // power-down last cycle
  logic        pd_fall;          // falling edge of power-down
  logic [4:0]  hold_cnt_q;       // module reset stretch
  logic        core_rst_n_q;     // reset of all module logic
  logic [6:0]  init_cnt_q;       // initialisation timer
  logic        ready;            // initialisation done
  logic        laser_want;       // wanted laser state
  logic        laser_en_q;       // laser drive
  logic        standby_q;        // low-power mode
  logic [24:0] sw_cnt_q;         // cycles laser lags its target
  logic        link_busy;        // open transaction, link side

  // release chain for the asynchronous reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) rst_sync_q <= 2'h0;
    else         rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n_s = rst_sync_q[1];

  // pins from outside pass two flops
  pin_sync #(.W(4), .RST_VAL(4'h0)) u_pin_sync (
    .clk   (ref_clk),
    .rst_n (rst_n_s),
    .d     ({link_busy, optical_los_in, power_down, laser_off_request}),
    .q     (pins_s)
  );
  assign dis_s   = pins_s[0];
  assign pd_s    = pins_s[1];
  assign los_s   = pins_s[2];
  assign busy_s  = pins_s[3];
  assign pd_fall = pd_prev_q & ~pd_s;

  // power-down edge detect and reset stretch
  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pd_prev_q    <= 1'b0;
      hold_cnt_q   <= 5'h0;
      core_rst_n_q <= 1'b0;
    end else begin
      pd_prev_q    <= pd_s;
      if (pd_fall)
        hold_cnt_q <= 5'(PD_HOLD_CYC);
      else if (hold_cnt_q != 5'h0)
        hold_cnt_q <= hold_cnt_q - 5'h1;
      core_rst_n_q <= (hold_cnt_q == 5'h0) && !pd_fall;
    end
  end

  // initialisation timer, restarts with every module reset
  always_ff @(posedge ref_clk or negedge core_rst_n_q) begin
    if (!core_rst_n_q)      init_cnt_q <= 7'h0;
    else if (!ready)        init_cnt_q <= init_cnt_q + 7'h1;
  end
  assign ready = (init_cnt_q == 7'(INIT_CYC));

  // laser off on request or in standby, registered on ref_clk
  assign laser_want = !dis_s && !pd_s && ready;

  // laser drive and standby
  always_ff @(posedge ref_clk or negedge core_rst_n_q) begin
    if (!core_rst_n_q) begin
      laser_en_q <= 1'b0;
      standby_q  <= 1'b0;
    end else begin
      laser_en_q <= laser_want;
      standby_q  <= pd_s;
    end
  end

  // lag counter, only for the switch-time check
  always_ff @(posedge ref_clk or negedge core_rst_n_q) begin
    if (!core_rst_n_q)               sw_cnt_q <= 25'h0;
    else if (laser_en_q != laser_want) sw_cnt_q <= sw_cnt_q + 25'h1;
    else                             sw_cnt_q <= 25'h0;
  end

  // monitors and flags
  logic [7:0] mon_in [N_MON];    // live inputs
  logic [7:0] mon_q  [N_MON];    // snapshot seen by the link
  logic [4:0] alarm_q;           // alarm flags
  logic [4:0] warn_q;            // warning flags
  logic [4:0] alarm_d;           // out of alarm range
  logic [4:0] warn_d;            // out of warning range
  logic [7:0] thr_q  [N_THR];    // thresholds, link domain
  logic [7:0] stat_byte;         // status byte

  assign mon_in[0] = temp_val;
  assign mon_in[1] = bias_val;
  assign mon_in[2] = txpow_val;
  assign mon_in[3] = rxpow_val;
  assign mon_in[4] = vcc_val;

  // per channel compare and snapshot, frozen while the link is busy
  for (genvar m = 0; m < N_MON; m++) begin : g_mon
    assign alarm_d[m] = (mon_in[m] > thr_q[THR_AHI+m]) ||
                        (mon_in[m] < thr_q[THR_ALO+m]);
    assign warn_d[m]  = (mon_in[m] > thr_q[THR_WHI+m]) ||
                        (mon_in[m] < thr_q[THR_WLO+m]);
    always_ff @(posedge ref_clk or negedge core_rst_n_q) begin
      if (!core_rst_n_q) begin
        mon_q[m]   <= 8'h00;
        alarm_q[m] <= 1'b0;
        warn_q[m]  <= 1'b0;
      end else if (!busy_s) begin
        mon_q[m]   <= mon_in[m];
        alarm_q[m] <= alarm_d[m];
        warn_q[m]  <= warn_d[m];
      end
    end
  end

  // status byte for the map
  assign stat_byte = {4'h0, standby_q, !ready, !laser_en_q, los_s};

  // open-collector pins
  // every line only pulls low or floats
  assign irq_n_o             = 1'b0;
  assign absent_o            = 1'b0;
  assign not_ready_flag_o    = 1'b0;
  assign rx_signal_lost_o    = 1'b0;
  assign sda_o               = 1'b0;
  assign irq_n_oe_n          = ~(|alarm_q || |warn_q);
  assign absent_oe_n         = 1'b0;
  assign not_ready_flag_oe_n = ~(ready && !pd_s);
  assign rx_signal_lost_oe_n = los_s;
  assign laser_enable        = laser_en_q;
  assign standby             = standby_q;

  // link domain, clocked by scl_i
  logic        start_tgl_q;      // flips on each start
  logic        stop_tgl_q;       // flips on each stop
  logic        open_q;           // stop toggle inverted at start
  logic        start_seen_q;     // last start taken by engine
  logic        start_new;        // start not yet taken
  logic        sel_n_s;          // module select, synchronised
  link_state_t st_q;             // engine state
  logic [2:0]  cnt_q;            // bit count in byte
  logic [7:0]  sh_q;             // receive shifter
  logic        rw_q;             // read transfer
  logic [7:0]  ptr_q;            // map pointer
  logic [7:0]  byte_in;          // byte with current bit
  logic        last_bit;         // eighth bit this edge
  logic [7:0]  ptr_next;         // advanced pointer
  logic        wr_ok;            // pointer on writable byte
  logic        wr_stb;           // store byte this edge
  logic [7:0]  thr_off;          // pointer inside threshold area
  logic [7:0]  rd_byte;          // byte addressed by pointer
  logic [7:0]  tx_q;             // read shifter
  logic        sda_drv_q;        // pull sda low

  // start: sda falls while scl high; host owns the clock
  always_ff @(negedge sda_i or negedge core_rst_n_q) begin
    if (!core_rst_n_q) begin
      start_tgl_q <= 1'b0;
      open_q      <= 1'b0;
    end else if (scl_i) begin
      start_tgl_q <= ~start_tgl_q;
      // a repeated start keeps the transaction open
      open_q      <= ~stop_tgl_q;
    end
  end

  // stop: sda rises while scl high
  always_ff @(posedge sda_i or negedge core_rst_n_q) begin
    if (!core_rst_n_q) stop_tgl_q <= 1'b0;
    else if (scl_i)    stop_tgl_q <= ~stop_tgl_q;
  end
  assign link_busy = open_q ^ stop_tgl_q;  // open from start to stop

  // module select reaches the engine over two scl edges
  pin_sync #(.W(1), .RST_VAL(1'b1)) u_sel_sync (
    .clk   (scl_i),
    .rst_n (core_rst_n_q),
    .d     (module_select_n),
    .q     (sel_n_s)
  );

  assign start_new = start_tgl_q != start_seen_q;
  assign byte_in   = {sh_q[6:0], sda_i};
  assign last_bit  = cnt_q == 3'h7;
  assign ptr_next  = (ptr_q == ADDR_MAX) ? ADDR_MON0 : ptr_q + 8'h01;
  assign wr_ok     = (ptr_q >= ADDR_THR0) && (ptr_q <= ADDR_MAX);
  assign wr_stb    = !start_new && st_q == ST_WDATA && last_bit && wr_ok;
  assign thr_off   = ptr_q - ADDR_THR0;

  // one byte per address
  assign rd_byte =
    (ptr_q <  ADDR_ALRM) ? mon_q[ptr_q[2:0]] :
    (ptr_q == ADDR_ALRM) ? {3'h0, alarm_q}   :
    (ptr_q == ADDR_WARN) ? {3'h0, warn_q}    :
    (ptr_q == ADDR_STAT) ? stat_byte         :
    (ptr_q <= ADDR_MAX)  ? thr_q[thr_off[4:0]] : 8'h00;

  // engine: samples sda on rising scl
  always_ff @(posedge scl_i or negedge core_rst_n_q) begin
    if (!core_rst_n_q) begin
      start_seen_q <= 1'b0;
      st_q         <= ST_IDLE;
      cnt_q        <= 3'h0;
      sh_q         <= 8'h00;
      rw_q         <= 1'b0;
      ptr_q        <= ADDR_MON0;
    end else if (start_new) begin
      // first address bit comes with this edge
      start_seen_q <= start_tgl_q;
      st_q         <= ST_ADDR;
      cnt_q        <= 3'h1;
      sh_q         <= {7'h00, sda_i};
    end else begin
      cnt_q <= cnt_q + 3'h1;
      sh_q  <= byte_in;
      case (st_q)
        ST_ADDR: begin
          if (last_bit) begin
            rw_q <= byte_in[0];
            // deselected modules stay silent
            if (byte_in[7:1] == DEV_ADDR && !sel_n_s) st_q <= ST_ACK_ADDR;
            else                                     st_q <= ST_IDLE;
          end
        end
        ST_ACK_ADDR: begin
          cnt_q <= 3'h0;
          st_q  <= rw_q ? ST_RDATA : ST_PTR;
        end
        ST_PTR: begin
          if (last_bit) begin
            ptr_q <= byte_in;
            st_q  <= ST_ACK_PTR;
          end
        end
        ST_ACK_PTR: begin
          cnt_q <= 3'h0;
          st_q  <= ST_WDATA;
        end
        ST_WDATA: begin
          if (last_bit) st_q <= ST_ACK_W;
        end
        ST_ACK_W: begin
          cnt_q <= 3'h0;
          ptr_q <= ptr_next;
          st_q  <= ST_WDATA;
        end
        ST_RDATA: begin
          if (last_bit) begin
            ptr_q <= ptr_next;
            st_q  <= ST_ACK_R;
          end
        end
        ST_ACK_R: begin
          // host ack continues, nack ends the read
          cnt_q <= 3'h0;
          st_q  <= sda_i ? ST_IDLE : ST_RDATA;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // writable threshold bytes; protected area has no storage
  for (genvar t = 0; t < N_THR; t++) begin : g_thr
    localparam logic [7:0] RV = (t < THR_ALO) ? AHI_RST :
                                (t < THR_WHI) ? ALO_RST :
                                (t < THR_WLO) ? WHI_RST : WLO_RST;
    always_ff @(posedge scl_i or negedge core_rst_n_q) begin
      if (!core_rst_n_q)
        thr_q[t] <= RV;
      else if (wr_stb && thr_off == 8'(t))
        thr_q[t] <= byte_in;
    end
  end

  // sda driver, changes only on falling scl
  always_ff @(negedge scl_i or negedge core_rst_n_q) begin
    if (!core_rst_n_q) begin
      sda_drv_q <= 1'b0;
      tx_q      <= 8'h00;
    end else if (st_q == ST_RDATA && cnt_q == 3'h0) begin
      sda_drv_q <= ~rd_byte[7];
      tx_q      <= {rd_byte[6:0], 1'b1};
    end else if (st_q == ST_RDATA) begin
      sda_drv_q <= ~tx_q[7];
      tx_q      <= {tx_q[6:0], 1'b1};
    end else begin
      // device ack slots pull low, host ack and all other slots release
      sda_drv_q <= (st_q == ST_ACK_ADDR) || (st_q == ST_ACK_PTR) ||
                   (st_q == ST_ACK_W);
    end
  end
  assign sda_oe_n = ~sda_drv_q;

  // checks
  AST_LASER_OFF: assert property (@(posedge ref_clk)
    disable iff (!core_rst_n_q) dis_s |=> !laser_en_q)
    else $error("laser still on after disable");

  AST_LASER_TIME: assert property (@(posedge ref_clk)
    disable iff (!core_rst_n_q) sw_cnt_q < SWITCH_CYC)
    else $error("laser switch too slow");

  AST_ABSENT: assert property (@(posedge ref_clk)
    disable iff (!core_rst_n_q) !absent_oe_n && !absent_o)
    else $error("absent line not pulled low");

  AST_LOS: assert property (@(posedge ref_clk)
    disable iff (!core_rst_n_q)
    rx_signal_lost_oe_n == $past(optical_los_in, 2))
    else $error("loss of signal pin does not follow input");

  AST_PD_RESET: assert property (@(posedge ref_clk)
    disable iff (!rst_n_s) pd_fall |=> !core_rst_n_q [*8])
    else $error("power-down edge gave no reset");

  AST_STANDBY: assert property (@(posedge ref_clk)
    disable iff (!core_rst_n_q)
    pd_s ##1 pd_s |-> standby_q && !laser_en_q && not_ready_flag_oe_n)
    else $error("standby not held");

  AST_NOT_READY: assert property (@(posedge ref_clk)
    disable iff (!rst_n_s)
    $rose(core_rst_n_q) |-> not_ready_flag_oe_n [*8])
    else $error("ready before initialisation");

  AST_IRQ: assert property (@(posedge ref_clk)
    disable iff (!core_rst_n_q)
    $rose(|alarm_q) |-> !irq_n_oe_n && !irq_n_o)
    else $error("flag pending without interrupt");

  AST_SELECT: assert property (@(posedge scl_i)
    disable iff (!core_rst_n_q)
    st_q == ST_ACK_ADDR |-> !sel_n_s && sh_q[7:1] == DEV_ADDR)
    else $error("answered while deselected");

  AST_ACK_DRIVE: assert property (@(posedge scl_i)
    disable iff (!core_rst_n_q)
    (st_q == ST_ACK_W || st_q == ST_ACK_PTR) |-> !sda_oe_n)
    else $error("write not acknowledged");

endmodule : optical_module_mgmt_control

`default_nettype wire

/* tb/host_model.sv */
// host-side two-wire controller model: drives scl, pulls sda low
// assumes the bench resolves sda as a pulled-up wire
`timescale 1ns/1ps
`default_nettype none

module host_model
  import optical_mgmt_pkg::*;
(
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  logic [7:0] wr_q [$];  // bytes sent after the pointer
  logic [7:0] rd_q [$];  // bytes read back
  logic       nak;       // some byte went unacknowledged

  // scl idles high and stands still between frames
  initial begin
    scl      = 1'b1;  // only the host drives the clock
    sda_pull = 1'b0;
    nak      = 1'b0;
  end

  // one 12 ns clock, data moved only while scl low
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;  // drive low or release
    #3 scl = 1'b1;
    #3 r = sda;
    #3 scl = 1'b0;
    #3;
  endtask : bit_io

  // start or repeated start: sda falls while scl high
  task automatic start_cond;
    sda_pull = 1'b0;
    #3 scl = 1'b1;
    #3 sda_pull = 1'b1;
    #6 scl = 1'b0;
    #3;
  endtask : start_cond

  // stop: sda rises while scl high, then idle
  task automatic stop_cond;
    sda_pull = 1'b1;
    #3 scl = 1'b1;
    #3 sda_pull = 1'b0;
    #6;
  endtask : stop_cond

  // msb first, then the device's acknowledge slot
  task automatic send_byte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);  // line released for the device
    if (r) nak = 1'b1;
  endtask : send_byte

  // eight released bits, then host ack or nack
  task automatic recv_byte(input logic last);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);  // device's turn
      d[i] = r;
    end
    bit_io(last, r);
    rd_q.push_back(d);
  endtask : recv_byte

  // pointer write followed by the queued data bytes
  task automatic do_write(input logic [7:0] ptr);
    nak = 1'b0;
    start_cond();
    send_byte({DEV_ADDR, 1'b0});
    if (!nak) begin
      send_byte(ptr);
      foreach (wr_q[i]) send_byte(wr_q[i]);
    end
    stop_cond();
    wr_q.delete();
  endtask : do_write

  // random or sequential read through a repeated start
  task automatic do_read(input logic [7:0] ptr, input int n);
    nak = 1'b0;
    rd_q.delete();
    start_cond();
    send_byte({DEV_ADDR, 1'b0});
    send_byte(ptr);
    start_cond();
    send_byte({DEV_ADDR, 1'b1});
    for (int i = 0; i < n; i++) recv_byte(i == n - 1);
    stop_cond();
  endtask : do_read
endmodule : host_model

`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the optical module management block
// assumes host_model as serial host and the package map layout
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import optical_mgmt_pkg::*;
  logic ref_clk, arst_n, module_select_n, laser_off_request, live;
  logic power_down, optical_los_in, scl, sda_pull, sda_o, sda_oe_n;
  logic laser_enable, standby, irq_n_o, irq_n_oe_n, absent_o;
  logic absent_oe_n, nr_o, nr_oe_n, los_o, los_oe_n;
  wire  sda = !(sda_pull || !sda_oe_n);  // pulled-up wire
  int   mon [5], thr [20], fail_count, n_tests, seed;

  host_model u_host_model (.scl, .sda_pull, .sda);
  optical_module_mgmt_control #(.SWITCH_CYC(16))
    u_optical_module_mgmt_control (.ref_clk, .arst_n, .scl_i(scl),
    .sda_i(sda), .sda_o, .sda_oe_n, .module_select_n, .laser_off_request,
    .power_down, .optical_los_in, .temp_val(8'(mon[0])),
    .bias_val(8'(mon[1])), .txpow_val(8'(mon[2])), .rxpow_val(8'(mon[3])),
    .vcc_val(8'(mon[4])), .laser_enable, .standby, .irq_n_o, .irq_n_oe_n,
    .absent_o, .absent_oe_n, .not_ready_flag_o(nr_o),
    .not_ready_flag_oe_n(nr_oe_n), .rx_signal_lost_o(los_o),
    .rx_signal_lost_oe_n(los_oe_n));

  // 200 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic set_defaults;
    foreach (thr[i]) thr[i] = i < 5 ? AHI_RST : i < 10 ? ALO_RST :
                              i < 15 ? WHI_RST : WLO_RST;
  endtask : set_defaults

  // not ready must stand until init ends, then pull low
  task automatic wait_ready;
    cyc(INIT_CYC - 8);
    check(nr_oe_n, 1'b1);
    for (int k = 0; k < 40 && nr_oe_n !== 1'b0; k++) cyc(1);
    check(nr_oe_n, 1'b0);
  endtask : wait_ready

  // reference model of one map byte
  function automatic logic [7:0] exp_byte(input int a);
    logic [7:0] al, wn;
    al = '0;
    wn = '0;
    for (int i = 0; i < 5; i++) begin
      al[i] = mon[i] > thr[THR_AHI+i] || mon[i] < thr[THR_ALO+i];
      wn[i] = mon[i] > thr[THR_WHI+i] || mon[i] < thr[THR_WLO+i];
    end
    if (a > ADDR_MAX) return 8'h00;
    if (a < 5) return 8'(mon[a]);
    if (a == 5) return al;
    if (a == 6) return wn;
    if (a == 7)
      return {4'h0, power_down, 1'b0, laser_off_request, optical_los_in};
    return 8'(thr[a-8]);
  endfunction : exp_byte

  // device data may only move while scl is low
  always @(sda_oe_n) if (live) check(scl, 1'b0);

  // watchdog well beyond the expected run time
  initial begin
    #200_000;
    fail_count++;
    $display("BAD t=%0t watchdog expired", $time);
    final_report();
  end

  initial begin
    arst_n = 1'b0;
    module_select_n = 1'b0;  // host selects this module
    {laser_off_request, power_down, optical_los_in, live} = '0;
    {fail_count, n_tests} = '0;
    seed = 32'ha311_960c;
    foreach (mon[i]) mon[i] = 0;
    set_defaults();
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    wait_ready();
    live = 1'b1;
    check(absent_oe_n, 1'b0);
    check({sda_o, irq_n_o, absent_o, nr_o, los_o}, 8'h00);
    $display("reset test done");
    for (int k = 0; k < 6; k++) begin
      @(posedge ref_clk);
      laser_off_request <= k[0];
      optical_los_in <= 1'($random(seed));
      cyc(8);
      check(laser_enable, !laser_off_request);
      check(los_oe_n, optical_los_in);
    end
    $display("pin test done");
    for (int k = 0; k < 2; k++) begin
      int a;
      for (int i = 0; i < 22; i++) begin
        logic [7:0] b;
        b = k ? ((i / 5) % 2 ? 8'h00 : 8'hFF) : 8'($random(seed));
        if (i < 20) thr[i] = b;
        u_host_model.wr_q.push_back(b);
      end
      u_host_model.do_write(ADDR_THR0);
      check(u_host_model.nak, 1'b0);
      @(posedge ref_clk);
      foreach (mon[i]) mon[i] <= $random(seed) & 255;
      cyc(10);
      u_host_model.do_read(ADDR_MON0, 29);
      for (int i = 0; i < 29; i++)
        check(u_host_model.rd_q[i], exp_byte(i % 28));
      check(irq_n_oe_n, (exp_byte(5) | exp_byte(6)) == 8'h00);
      a = ($random(seed) & 32'h7fff_ffff) % 32;
      u_host_model.do_read(8'(a), 1);
      check(u_host_model.rd_q[0], exp_byte(a));
    end
    $display("map test done");
    @(posedge ref_clk);
    module_select_n <= 1'b1;
    cyc(4);
    u_host_model.wr_q.push_back(8'h5A);
    u_host_model.do_write(ADDR_THR0);
    check(u_host_model.nak, 1'b1);
    @(posedge ref_clk);
    module_select_n <= 1'b0;
    u_host_model.do_read(ADDR_THR0, 1);
    check(u_host_model.rd_q[0], exp_byte(8));
    $display("select test done");
    @(posedge ref_clk);
    power_down <= 1'b1;
    cyc(8);
    check(standby, 1'b1);
    check(laser_enable, 1'b0);
    @(posedge ref_clk);
    power_down <= 1'b0;
    cyc(6);
    check(nr_oe_n, 1'b1);
    set_defaults();
    wait_ready();
    check(standby, 1'b0);
    u_host_model.do_read(ADDR_THR0, 20);
    for (int i = 0; i < 20; i++)
      check(u_host_model.rd_q[i], exp_byte(i + 8));
    $display("power-down test done");
    final_report();
  end
endmodule : testbench

`default_nettype wire
